// *** rtl/ebc_map.vh ***
// Constants for the external memory bus control block
//
// Behaviour
// - Read strobe low only during external read cycles, never writes or idle.
// - Latch strobe pulses high only in external cycles, marking address and start.
// - chip_cfg bit 3 selects latch strobe (1) or address valid low form (0).
// - Address valid low through whole external cycle, high when cycle ends.
// - Fetch flag high for instruction fetches, low for data cycles.
// - Width pin sampled each cycle when enabled: high 16-bit, low 8-bit.
// - chip_cfg bit 1 enables width pin; cleared forces 8-bit cycles.
// - clock_output is half the oscillator rate with 50% duty.
// - clock_output driven on pin only while io_cfg3 bit 1 is clear.
// - Each wait state stretches strobe and data by two oscillator periods.
// - Ready low at clock_output fall adds another wait state.
// - Ready sampled at clock_output falls; waits stop on ready or max count.
// - Separate mode: high write strobe for high/word 16-bit, all 8-bit writes.
// - Low write strobe for low byte 16-bit writes, all 8-bit writes.
`ifndef EBC_MAP_VH
`define EBC_MAP_VH

////////////////////////////////////////////////////////////////////////
// Register offsets
`define EBC_OFS_CHIP_CFG 4'h0
`define EBC_OFS_IO_CFG3 4'h1
`define EBC_OFS_STATUS 4'h2

////////////////////////////////////////////////////////////////////////
// Field positions
`define EBC_CCR_WIDTH_EN 1
`define EBC_CCR_WR_MODE 2
`define EBC_CCR_LATCH_FORM 3
`define EBC_CCR_WAIT_LO 4
`define EBC_CCR_WAIT_HI 5
`define EBC_IO_CFG3_CLK_DIS 1

////////////////////////////////////////////////////////////////////////
// Reset values
`define EBC_CHIP_CFG_RST 8'h08
`define EBC_IO_CFG3_RST 8'h00

////////////////////////////////////////////////////////////////////////
// Timing counts in oscillator periods, and synchroniser stage count
`define EBC_OSC_PER_WAIT 2
`define EBC_OSC_PER_CYCLE 4
`define EBC_SYNC_STAGES 3

`endif

// *** rtl/ebc_sync.v ***
// Three stage input synchroniser with agreement filter
`timescale 1ns/10ps
module ebc_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input wire clk_in,
  input wire rstn_in,
  // Data
  input wire [WIDTH-1:0] d_in,
  output reg [WIDTH-1:0] q_out
);

  reg [WIDTH-1:0] s1_ff;
  reg [WIDTH-1:0] s2_ff;
  reg [WIDTH-1:0] s3_ff;
  integer i;

  ////////////////////////////////////////////////////////////////////////
  // Stage one is read only by stage two
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s1_ff <= {WIDTH{1'b0}};
      s2_ff <= {WIDTH{1'b0}};
      s3_ff <= {WIDTH{1'b0}};
      q_out <= {WIDTH{1'b0}};
    end else begin
      s1_ff <= d_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      for (i = 0; i < WIDTH; i = i + 1) begin
        // A bit changes only when two stages agree
        if (s2_ff[i] == s3_ff[i]) begin
          q_out[i] <= s3_ff[i];
        end
      end
    end
  end

endmodule // ebc_sync

// *** rtl/ebc_top.v ***
// External memory bus controller: strobes, waits, width and clock output
`timescale 1ns/10ps
`include "ebc_map.vh"
module ebc_top #(
  parameter AW = 16,
  parameter DW = 16
) (
  // Clock and reset
  input wire REF_CLK_IN,
  input wire RSTN_IN,
  // Register port
  input wire [3:0] REG_ADDR_IN,
  input wire [7:0] REG_WDATA_IN,
  input wire REG_WR_IN,
  input wire REG_RD_IN,
  output reg [7:0] REG_RDATA_OUT,
  // Bus cycle requests
  input wire CYC_REQ_IN,
  input wire CYC_WRITE_IN,
  input wire CYC_FETCH_IN,
  input wire [AW-1:0] CYC_ADDR_IN,
  input wire [DW-1:0] CYC_WDATA_IN,
  input wire [1:0] CYC_BYTE_EN_IN,
  output wire CYC_READY_OUT,
  output reg CYC_DONE_OUT,
  output reg [DW-1:0] CYC_RDATA_OUT,
  // Pin inputs
  input wire OSC_INPUT_IN,
  input wire READY_IN,
  input wire BUS_WIDTH_SELECT_IN,
  input wire [DW-1:0] AD_IN,
  // Pin outputs
  output reg [DW-1:0] AD_OUT,
  output reg [DW-1:0] AD_OE_OUT,
  output reg READ_STROBE_N_OUT,
  output reg LATCH_STROBE_OUT,
  output reg FETCH_KIND_FLAG_OUT,
  output reg WRITE_LOW_STROBE_N_OUT,
  output reg WRITE_HIGH_STROBE_N_OUT,
  output wire CLOCK_OUTPUT_OUT,
  output wire CLOCK_OUTPUT_OE_OUT
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_HOLD = 3'h2;
  localparam [2:0] ST_STRB1 = 3'h3;
  localparam [2:0] ST_STRB2 = 3'h4;
  localparam [2:0] ST_WAITA = 3'h5;
  localparam [2:0] ST_WAITB = 3'h6;
  localparam HB = DW / 2;

  reg [7:0] chip_cfg_ff;
  reg [7:0] io_cfg3_ff;
  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg pend_ff;
  reg req_write_ff;
  reg req_fetch_ff;
  reg [AW-1:0] req_addr_ff;
  reg [DW-1:0] req_wdata_ff;
  reg [1:0] req_be_ff;
  reg second_ff;
  reg nxt_second;
  reg wide_ff;
  reg nxt_wide;
  reg [1:0] wait_cnt_ff;
  reg [1:0] nxt_wait_cnt;
  reg [1:0] last_wait_ff;
  reg [DW-1:0] rdata_ff;
  reg nxt_done;
  reg clk_out_ff;
  reg osc_prev_ff;
  wire osc_q;
  wire ready_q;
  wire width_q;
  wire [DW-1:0] ad_q;
  wire osc_tick;
  wire fall_tick;
  wire [1:0] wait_max;
  wire pin_wide;
  wire ready_ok;
  wire need_pair;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  ebc_sync #(.WIDTH(1)) u_sync_osc (
    .clk_in(REF_CLK_IN),
    .rstn_in(RSTN_IN),
    .d_in(OSC_INPUT_IN),
    .q_out(osc_q)
  );

  ebc_sync #(.WIDTH(2)) u_sync_ctl (
    .clk_in(REF_CLK_IN),
    .rstn_in(RSTN_IN),
    .d_in({BUS_WIDTH_SELECT_IN, READY_IN}),
    .q_out({width_q, ready_q})
  );

  ebc_sync #(.WIDTH(DW)) u_sync_ad (
    .clk_in(REF_CLK_IN),
    .rstn_in(RSTN_IN),
    .d_in(AD_IN),
    .q_out(ad_q)
  );

  ////////////////////////////////////////////////////////////////////////
  // Oscillator edges and divided clock
  assign osc_tick = osc_q & ~osc_prev_ff;
  // Cycles start only where clock_output falls, keeping phases aligned
  assign fall_tick = osc_tick & clk_out_ff;
  assign CLOCK_OUTPUT_OUT = clk_out_ff;
  assign CLOCK_OUTPUT_OE_OUT = ~io_cfg3_ff[`EBC_IO_CFG3_CLK_DIS];

  always @(posedge REF_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      osc_prev_ff <= 1'b0;
      clk_out_ff <= 1'b0;
    end else begin
      osc_prev_ff <= osc_q;
      if (osc_tick) begin
        clk_out_ff <= ~clk_out_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register port
  always @(posedge REF_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      chip_cfg_ff <= `EBC_CHIP_CFG_RST;
      io_cfg3_ff <= `EBC_IO_CFG3_RST;
      REG_RDATA_OUT <= 8'h00;
    end else begin
      if (REG_WR_IN) begin
        if (REG_ADDR_IN == `EBC_OFS_CHIP_CFG) begin
          chip_cfg_ff <= REG_WDATA_IN;
        end else if (REG_ADDR_IN == `EBC_OFS_IO_CFG3) begin
          io_cfg3_ff <= REG_WDATA_IN;
        end
      end
      // Read data stands for one cycle only, zero otherwise
      if (!REG_RD_IN) begin
        REG_RDATA_OUT <= 8'h00;
      end else if (REG_ADDR_IN == `EBC_OFS_CHIP_CFG) begin
        REG_RDATA_OUT <= chip_cfg_ff;
      end else if (REG_ADDR_IN == `EBC_OFS_IO_CFG3) begin
        REG_RDATA_OUT <= io_cfg3_ff;
      end else if (REG_ADDR_IN == `EBC_OFS_STATUS) begin
        REG_RDATA_OUT <= {2'h0, last_wait_ff, 1'b0, second_ff, wide_ff,
          pend_ff};
      end else begin
        REG_RDATA_OUT <= 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Cycle sequencing
  assign wait_max = chip_cfg_ff[`EBC_CCR_WAIT_HI:`EBC_CCR_WAIT_LO];
  assign pin_wide = chip_cfg_ff[`EBC_CCR_WIDTH_EN] & width_q;
  assign ready_ok = ready_q | (wait_cnt_ff == wait_max);
  // A word on an 8-bit bus takes two cycles, low byte first
  assign need_pair = ~wide_ff & ~second_ff & (req_be_ff == 2'b11);
  assign CYC_READY_OUT = ~pend_ff;

  always @* begin
    nxt_state = state_ff;
    nxt_second = second_ff;
    nxt_wide = wide_ff;
    nxt_wait_cnt = wait_cnt_ff;
    nxt_done = 1'b0;
    if (osc_tick) begin
      case (state_ff)
        ST_IDLE: begin
          if (pend_ff && fall_tick) begin
            nxt_state = ST_ADDR;
            nxt_wait_cnt = 2'h0;
          end
        end
        ST_ADDR: begin
          nxt_state = ST_HOLD;
        end
        ST_HOLD: begin
          // Width and ready both sampled at this clock_output fall
          nxt_wide = pin_wide;
          if (ready_ok) begin
            nxt_state = ST_STRB1;
          end else begin
            nxt_state = ST_WAITA;
            nxt_wait_cnt = wait_cnt_ff + 2'h1;
          end
        end
        ST_WAITA: begin
          nxt_state = ST_WAITB;
        end
        ST_WAITB: begin
          if (ready_ok) begin
            nxt_state = ST_STRB1;
          end else begin
            nxt_state = ST_WAITA;
            nxt_wait_cnt = wait_cnt_ff + 2'h1;
          end
        end
        ST_STRB1: begin
          nxt_state = ST_STRB2;
        end
        ST_STRB2: begin
          if (need_pair) begin
            nxt_state = ST_ADDR;
            nxt_second = 1'b1;
            nxt_wait_cnt = 2'h0;
          end else begin
            nxt_state = ST_IDLE;
            nxt_second = 1'b0;
            nxt_done = 1'b1;
          end
        end
        default: begin
          nxt_state = ST_IDLE;
        end
      endcase
    end
  end

  always @(posedge REF_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      state_ff <= ST_IDLE;
      second_ff <= 1'b0;
      wide_ff <= 1'b0;
      wait_cnt_ff <= 2'h0;
      last_wait_ff <= 2'h0;
      pend_ff <= 1'b0;
      req_write_ff <= 1'b0;
      req_fetch_ff <= 1'b0;
      req_addr_ff <= {AW{1'b0}};
      req_wdata_ff <= {DW{1'b0}};
      req_be_ff <= 2'h0;
      rdata_ff <= {DW{1'b0}};
      CYC_DONE_OUT <= 1'b0;
      CYC_RDATA_OUT <= {DW{1'b0}};
    end else begin
      state_ff <= nxt_state;
      second_ff <= nxt_second;
      wide_ff <= nxt_wide;
      wait_cnt_ff <= nxt_wait_cnt;
      CYC_DONE_OUT <= nxt_done;
      if (CYC_REQ_IN && !pend_ff) begin
        pend_ff <= 1'b1;
        req_write_ff <= CYC_WRITE_IN;
        req_fetch_ff <= CYC_FETCH_IN;
        req_addr_ff <= CYC_ADDR_IN;
        req_wdata_ff <= CYC_WDATA_IN;
        // No lanes named means a whole word
        req_be_ff <= (CYC_BYTE_EN_IN == 2'h0) ? 2'h3 : CYC_BYTE_EN_IN;
      end else if (nxt_done) begin
        pend_ff <= 1'b0;
      end
      if (osc_tick && state_ff == ST_STRB2) begin
        last_wait_ff <= wait_cnt_ff;
        if (wide_ff) begin
          rdata_ff <= ad_q;
        end else if (second_ff || req_be_ff == 2'b10) begin
          rdata_ff <= {ad_q[HB-1:0], rdata_ff[HB-1:0]};
        end else begin
          rdata_ff <= {rdata_ff[DW-1:HB], ad_q[HB-1:0]};
        end
      end
      if (nxt_done) begin
        if (wide_ff) begin
          CYC_RDATA_OUT <= ad_q;
        end else if (second_ff || req_be_ff == 2'b10) begin
          CYC_RDATA_OUT <= {ad_q[HB-1:0], rdata_ff[HB-1:0]};
        end else begin
          CYC_RDATA_OUT <= {rdata_ff[DW-1:HB], ad_q[HB-1:0]};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin values, computed from the next state and registered
  reg nxt_active;
  reg nxt_strobe;
  reg nxt_hi;
  reg nxt_lo;
  reg [AW-1:0] nxt_addr;
  reg [HB-1:0] nxt_byte;
  reg [DW-1:0] nxt_ad;
  reg [DW-1:0] nxt_ad_oe;
  reg nxt_pin40;
  reg nxt_pin41;

  always @* begin
    nxt_active = (nxt_state != ST_IDLE);
    nxt_strobe = (nxt_state == ST_STRB1) || (nxt_state == ST_STRB2) ||
      (nxt_state == ST_WAITA) || (nxt_state == ST_WAITB);
    nxt_hi = nxt_wide ? req_be_ff[1] : (nxt_second | (req_be_ff == 2'b10));
    nxt_lo = nxt_wide ? req_be_ff[0] : ~nxt_hi;
    nxt_addr = nxt_second ? (req_addr_ff | {{(AW-1){1'b0}}, 1'b1}) :
      req_addr_ff;
    nxt_byte = nxt_hi ? req_wdata_ff[DW-1:HB] : req_wdata_ff[HB-1:0];
    nxt_ad = {DW{1'b0}};
    nxt_ad_oe = {DW{1'b0}};
    if (nxt_active && !nxt_strobe) begin
      nxt_ad = nxt_addr;
      nxt_ad_oe = {DW{1'b1}};
    end else if (nxt_strobe && req_write_ff) begin
      nxt_ad = nxt_wide ? req_wdata_ff : {nxt_addr[AW-1:HB], nxt_byte};
      nxt_ad_oe = {DW{1'b1}};
    end else if (nxt_strobe) begin
      // Reads release the data lanes; narrow cycles keep upper address
      nxt_ad = nxt_wide ? {DW{1'b0}} : {nxt_addr[AW-1:HB], {HB{1'b0}}};
      nxt_ad_oe = nxt_wide ? {DW{1'b0}} : {{HB{1'b1}}, {HB{1'b0}}};
    end
    if (chip_cfg_ff[`EBC_CCR_WR_MODE]) begin
      nxt_pin40 = ~(nxt_strobe & req_write_ff);
      nxt_pin41 = ~(nxt_active & nxt_hi);
    end else begin
      nxt_pin40 = ~(nxt_strobe & req_write_ff & (nxt_lo | ~nxt_wide));
      nxt_pin41 = ~(nxt_strobe & req_write_ff & (nxt_hi | ~nxt_wide));
    end
  end

  always @(posedge REF_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      // Read and write strobes idle high, latch strobe low, as the reset straps expect
      AD_OUT <= {DW{1'b0}};
      AD_OE_OUT <= {DW{1'b0}};
      READ_STROBE_N_OUT <= 1'b1;
      LATCH_STROBE_OUT <= 1'b0;
      FETCH_KIND_FLAG_OUT <= 1'b0;
      WRITE_LOW_STROBE_N_OUT <= 1'b1;
      WRITE_HIGH_STROBE_N_OUT <= 1'b1;
    end else begin
      AD_OUT <= nxt_ad;
      AD_OE_OUT <= nxt_ad_oe;
      READ_STROBE_N_OUT <= ~(nxt_strobe & ~req_write_ff);
      if (chip_cfg_ff[`EBC_CCR_LATCH_FORM]) begin
        LATCH_STROBE_OUT <= (nxt_state == ST_ADDR);
      end else begin
        LATCH_STROBE_OUT <= ~nxt_active;
      end
      FETCH_KIND_FLAG_OUT <= nxt_active & req_fetch_ff;
      WRITE_LOW_STROBE_N_OUT <= nxt_pin40;
      WRITE_HIGH_STROBE_N_OUT <= nxt_pin41;
    end
  end

endmodule // ebc_top

// *** tb/ebc_top_asserts.sv ***
// Checker for the external memory bus control block
`timescale 1ns/10ps
module ebc_chk #(
  parameter AW = 16,
  parameter DW = 16
) (
  // Clock and reset
  input wire REF_CLK_IN,
  input wire RSTN_IN,
  // Watched ports
  input wire [3:0] REG_ADDR_IN,
  input wire [7:0] REG_WDATA_IN,
  input wire REG_WR_IN,
  input wire CYC_READY_OUT,
  input wire [DW-1:0] AD_OE_OUT,
  input wire READ_STROBE_N_OUT,
  input wire LATCH_STROBE_OUT,
  input wire FETCH_KIND_FLAG_OUT,
  input wire WRITE_LOW_STROBE_N_OUT,
  input wire WRITE_HIGH_STROBE_N_OUT,
  input wire CLOCK_OUTPUT_OUT,
  input wire CLOCK_OUTPUT_OE_OUT
);
  ////////////////////////////////////////
  // Form lags one extra cycle: pin is registered after the config
  reg form_ff;
  reg form_d_ff;
  reg clkdis_ff;
  reg [6:0] rd_cnt_ff;
  always @(posedge REF_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      form_ff <= 1'b1;
      form_d_ff <= 1'b1;
      clkdis_ff <= 1'b0;
      rd_cnt_ff <= 7'h00;
    end else begin
      if (REG_WR_IN && REG_ADDR_IN == 4'h0) form_ff <= REG_WDATA_IN[3];
      if (REG_WR_IN && REG_ADDR_IN == 4'h1) clkdis_ff <= REG_WDATA_IN[1];
      form_d_ff <= form_ff;
      rd_cnt_ff <= READ_STROBE_N_OUT ? 7'h00 : rd_cnt_ff + 7'h01;
    end
  end
  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (!RSTN_IN);
  ////////////////////////////////////////
  a_rd_only_read: assert property (!READ_STROBE_N_OUT |->
    !CYC_READY_OUT && WRITE_LOW_STROBE_N_OUT) else $error("stray read");
  a_rd_bus_free: assert property (!READ_STROBE_N_OUT |->
    AD_OE_OUT[7:0] == 8'h00) else $error("bus driven in read");
  a_ale_in_cycle: assert property (form_d_ff && LATCH_STROBE_OUT |->
    !CYC_READY_OUT && &AD_OE_OUT) else $error("stray latch pulse");
  a_ale_width: assert property (form_d_ff && $rose(LATCH_STROBE_OUT)
    |-> LATCH_STROBE_OUT[*8] ##1 !LATCH_STROBE_OUT) else $error("latch len");
  a_adv_in_cycle: assert property (!form_d_ff && !LATCH_STROBE_OUT
    |-> !CYC_READY_OUT) else $error("stray address valid");
  a_fetch_in_cycle: assert property (FETCH_KIND_FLAG_OUT |->
    !CYC_READY_OUT) else $error("fetch flag when idle");
  a_clk_high: assert property ($rose(CLOCK_OUTPUT_OUT) |->
    CLOCK_OUTPUT_OUT[*8] ##1 !CLOCK_OUTPUT_OUT) else $error("clock high");
  a_clk_low: assert property ($fell(CLOCK_OUTPUT_OUT) |->
    !CLOCK_OUTPUT_OUT[*8] ##1 CLOCK_OUTPUT_OUT) else $error("clock low");
  a_clk_pin_en: assert property (CLOCK_OUTPUT_OE_OUT == !clkdis_ff)
    else $error("clock enable wrong");
  a_rd_len: assert property ($rose(READ_STROBE_N_OUT) |->
    rd_cnt_ff[3:0] == 4'h0 && rd_cnt_ff != 7'h00 && rd_cnt_ff <= 7'h40)
    else $error("read strobe length");
  a_wr_only_write: assert property (!WRITE_LOW_STROBE_N_OUT |->
    READ_STROBE_N_OUT && !CYC_READY_OUT) else $error("stray write");
  a_reset_idle: assert property (disable iff (1'b0) $rose(RSTN_IN) |->
    READ_STROBE_N_OUT && WRITE_LOW_STROBE_N_OUT && WRITE_HIGH_STROBE_N_OUT)
    else $error("strobe low at reset release");
  c_latch_form: cover property (form_d_ff && $fell(LATCH_STROBE_OUT));
  c_valid_form: cover property (!form_d_ff && $fell(LATCH_STROBE_OUT));
  c_write_high: cover property ($fell(WRITE_HIGH_STROBE_N_OUT));
endmodule // ebc_chk

// *** tb/ebc_mem.sv ***
// Model of external memory, address latch and slow peripheral
`timescale 1ns/10ps
module ebc_mem (
  // Clock and bench settings
  input wire clk_in,
  input wire wide_in,
  input wire [1:0] waits_in,
  // Lanes really in use, and combined write/byte-high strobe mode
  input wire lane16_in,
  input wire comb_in,
  // Controller pins
  input wire [15:0] bus_in,
  input wire [15:0] oe_in,
  input wire rd_n_in,
  input wire latch_in,
  input wire wrl_n_in,
  input wire wrh_n_in,
  // Pins back to the controller
  output wire [15:0] wire_out,
  output wire ready_out,
  output wire width_out
);
  reg [7:0] mem [0:65535];
  reg [15:0] addr_ff = 16'h0000;
  reg [6:0] cnt_ff = 7'h7f;
  reg latch_q_ff = 1'b0;
  wire [15:0] rd_data = {mem[addr_ff | 16'h0001], mem[addr_ff]};
  // Combined mode: low pin is the write, high pin the byte-high enable
  wire wr_lo = comb_in ? (!wrl_n_in && !addr_ff[0]) : !wrl_n_in;
  wire wr_hi = comb_in ? (!wrl_n_in && !wrh_n_in) : !wrh_n_in;
  ////////////////////////////////////////
  always @(posedge clk_in) begin
    latch_q_ff <= latch_in;
    if (latch_q_ff && !latch_in) begin
      addr_ff <= bus_in;
      cnt_ff <= 7'h00;
    end else if (cnt_ff != 7'h7f) begin
      cnt_ff <= cnt_ff + 7'h01;
    end
    // Width pin may be high while ignored, so lanes follow the real width
    if (lane16_in) begin
      if (wr_lo) mem[addr_ff] <= bus_in[7:0];
      if (wr_hi) mem[addr_ff | 16'h0001] <= bus_in[15:8];
    end else if (!wrl_n_in && (comb_in || !wrh_n_in)) begin
      mem[addr_ff] <= bus_in[7:0];
    end
  end
  // Slow device: ready low mid-way between samples, so sync cannot blur it
  assign ready_out = cnt_ff >= {1'b0, waits_in, 4'h0};
  assign width_out = wide_in;
  // Pull-ups hold released lines high
  assign wire_out = (oe_in & bus_in) |
    (~oe_in & (rd_n_in ? 16'hffff : rd_data));
endmodule // ebc_mem

// *** tb/test_ebc_top.sv ***
// Testbench for the external memory bus control block
`timescale 1ns/10ps
module test_ebc_top;
  typedef struct packed {logic rd; logic fk; logic [15:0] d;
    logic [6:0] n;} ebc_exp_t;
  reg clk, rstn, osc, rwr, rrd, req, wr, fch, wide, rd_d;
  reg [3:0] raddr;
  reg [7:0] rwdata, c;
  reg [15:0] addr, wdata, a, d;
  reg [1:0] be, waits;
  reg [31:0] seed = 32'h9f60_206e;
  reg [6:0] lo_n = 7'h00;
  reg fk_seen = 1'b0;
  localparam [55:0] cfg_list = 56'h0e_1a02_2a0a_0a08;
  localparam [6:0] wide_list = 7'h5b;
  localparam [13:0] wait_list = 14'h24c0;
  integer fails = 0, total_checks = 0, i, nw, len;
  wire [7:0] rdata;
  wire [15:0] crdata, ad_in, ad_out, ad_oe;
  wire cready, cdone, ready, bw, rd_n, latch, fk, wrl_n, wrh_n;
  ebc_exp_t cq[$];
  ebc_exp_t e;
  reg [7:0] rq[$];
  ebc_top i_dut (.REF_CLK_IN(clk), .RSTN_IN(rstn), .REG_ADDR_IN(raddr),
    .REG_WDATA_IN(rwdata), .REG_WR_IN(rwr), .REG_RD_IN(rrd),
    .REG_RDATA_OUT(rdata), .CYC_REQ_IN(req), .CYC_WRITE_IN(wr),
    .CYC_FETCH_IN(fch), .CYC_ADDR_IN(addr), .CYC_WDATA_IN(wdata),
    .CYC_BYTE_EN_IN(be), .CYC_READY_OUT(cready), .CYC_DONE_OUT(cdone),
    .CYC_RDATA_OUT(crdata), .OSC_INPUT_IN(osc), .READY_IN(ready),
    .BUS_WIDTH_SELECT_IN(bw), .AD_IN(ad_in), .AD_OUT(ad_out),
    .AD_OE_OUT(ad_oe), .READ_STROBE_N_OUT(rd_n), .LATCH_STROBE_OUT(latch),
    .FETCH_KIND_FLAG_OUT(fk), .WRITE_LOW_STROBE_N_OUT(wrl_n),
    .WRITE_HIGH_STROBE_N_OUT(wrh_n), .CLOCK_OUTPUT_OUT(),
    .CLOCK_OUTPUT_OE_OUT());
  ebc_mem i_mem (.clk_in(clk), .wide_in(wide), .waits_in(waits),
    .lane16_in(wide & c[1]), .comb_in(c[2]),
    .bus_in(ad_out), .oe_in(ad_oe), .rd_n_in(rd_n), .latch_in(latch),
    .wrl_n_in(wrl_n), .wrh_n_in(wrh_n), .wire_out(ad_in),
    .ready_out(ready), .width_out(bw));
  ////////////////////////////////////////
  function automatic [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task chk(input [15:0] g, input [15:0] x);
    begin
      total_checks = total_checks + 1;
      if (g !== x) begin
        fails = fails + 1;
        $display("ERROR %0t got %h exp %h", $time, g, x);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task rw(input [3:0] ra, input [7:0] rd);
    begin
      @(posedge clk);
      raddr <= ra;
      rwdata <= rd;
      rwr <= 1'b1;
      @(posedge clk);
      rwr <= 1'b0;
    end
  endtask
  task rr(input [3:0] ra, input [7:0] x);
    begin
      rq.push_back(x);
      @(posedge clk);
      raddr <= ra;
      rrd <= 1'b1;
      @(posedge clk);
      rrd <= 1'b0;
    end
  endtask
  // One request at a time; next one only after done
  task cyc(input w, input f, input [15:0] ca, input [15:0] cd,
    input [1:0] b, input [6:0] n);
    integer k;
    begin
      cq.push_back({~w, f, cd, n});
      @(posedge clk);
      req <= 1'b1;
      wr <= w;
      fch <= f;
      addr <= ca;
      wdata <= cd;
      be <= b;
      @(posedge clk);
      req <= 1'b0;
      k = 0;
      @(negedge clk);
      while (cdone !== 1'b1 && k < 400) begin
        @(negedge clk);
        k = k + 1;
      end
      chk({15'h0000, cdone}, 16'h0001);
    end
  endtask
  ////////////////////////////////////////
  always @(posedge clk) rd_d <= rrd;
  always @(negedge clk) begin
    if (rd_d === 1'b1) chk({8'h00, rdata}, {8'h00, rq.pop_front()});
    if (rd_n === 1'b0) lo_n = lo_n + 7'h01;
    if (fk === 1'b1) fk_seen = 1'b1;
    if (cdone === 1'b1) begin
      e = cq.pop_front();
      if (e.rd) chk(crdata, e.d);
      chk({fk_seen, lo_n}, {e.fk, e.n});
      lo_n = 7'h00;
      fk_seen = 1'b0;
    end
  end
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    osc = 1'b0;
    #7;
    forever #100 osc = ~osc;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails = fails + 1;
    print_verdict;
  end
  initial begin
    {rstn, rwr, rrd, req, wr, fch, raddr, rwdata} = 0;
    {addr, wdata, be, wide, waits, c} = 0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rr(4'h0, 8'h08);
    rr(4'h1, 8'h00);
    rr(4'hf, 8'h00);
    rw(4'h1, 8'h02);
    rr(4'h1, 8'h02);
    rw(4'h1, 8'h00);
    $display("registers done");
    for (i = 0; i < 7; i = i + 1) begin
      c = cfg_list[8*i +: 8];
      rw(4'h0, c);
      wide <= wide_list[i];
      waits <= wait_list[2*i +: 2];
      #1;
      nw = (waits < c[5:4]) ? waits : c[5:4];
      len = 16 * (nw + 1) * ((c[1] && wide) ? 1 : 2);
      seed = xs(seed);
      a = {seed[15:1], 1'b0};
      d = seed[31:16];
      cyc(1'b1, 1'b0, a, d, 2'h0, 7'h00);
      cyc(1'b0, i[0], a, d, 2'h0, len[6:0]);
      cyc(1'b1, 1'b0, a, ~d, 2'h1, 7'h00);
      cyc(1'b0, 1'b0, a, {d[15:8], ~d[7:0]}, 2'h0, len[6:0]);
      rr(4'h2, {2'h0, nw[1:0], 2'h0, c[1] & wide, 1'b0});
      $display("case %0d done", i);
    end
    chk(cq.size(), 16'h0000);
    print_verdict;
  end
endmodule // test_ebc_top
bind ebc_top ebc_chk #(.AW(AW), .DW(DW)) u_chk (
  .REF_CLK_IN, .RSTN_IN, .REG_ADDR_IN, .REG_WDATA_IN, .REG_WR_IN,
  .CYC_READY_OUT, .AD_OE_OUT, .READ_STROBE_N_OUT, .LATCH_STROBE_OUT,
  .FETCH_KIND_FLAG_OUT, .WRITE_LOW_STROBE_N_OUT,
  .WRITE_HIGH_STROBE_N_OUT, .CLOCK_OUTPUT_OUT, .CLOCK_OUTPUT_OE_OUT);
